/* File: inc/ttfs_consts.svh */
`ifndef TTFS_CONSTS_SVH
`define TTFS_CONSTS_SVH

// Register indices, byte address is four times the index
`define TTFS_IDX_FMT_CTRL    12'h183
`define TTFS_IDX_IO_CFG      12'h184
`define TTFS_IDX_SYNC_CTRL   12'h18e
`define TTFS_IDX_LAT_STAT3   12'h192
`define TTFS_IDX_INT_MASK3   12'h1a2
`define TTFS_IDX_ES_MODE     12'h1b0
`define TTFS_IDX_SYNC_STAT   12'h1b1
`define TTFS_FRAMER_STRIDE   12'h200

// Field positions
`define TTFS_FMT_SEL_BIT     2
`define TTFS_MF_SEL_BIT      0
`define TTFS_DIR_BIT         2
`define TTFS_THR_SEL_BIT     0
`define TTFS_RESYNC_BIT      1
`define TTFS_LOSS_OF_FRAME_DETECTED_BIT        0
`define TTFS_LOSS_OF_FRAME_DETECTED_MASK_BIT   0
`define TTFS_ES_EN_BIT       0
`define TTFS_IBO_BIT         1

// Reset values
`define TTFS_REG_RST         8'h00

// Framing constants
`define TTFS_BIT_LAST        8'd192
`define TTFS_D4_LAST         5'd11
`define TTFS_ESF_LAST        5'd23
`define TTFS_HIST_LEN        5'd24
`define TTFS_D4_PATTERN      12'h3b1
`define TTFS_ESF_PATTERN     6'h34
`define TTFS_ERR_THR_LO      3'd2
`define TTFS_ERR_THR_HI      3'd4

`endif

/* File: inc/ttfs_pkg.sv */
package ttfs_pkg;

	localparam int APB_AW = 14;
	localparam int APB_DW = 32;

	typedef enum logic [2:0]
	{
		S_IDLE = 3'b001,
		S_HUNT = 3'b010,
		S_LOCK = 3'b100
	} ttfs_state_e;

	typedef struct packed
	{
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [APB_AW-1:0] paddr;
		logic [APB_DW-1:0] pwdata;
	} ttfs_apb_req_s;

	typedef struct packed
	{
		logic [APB_DW-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} ttfs_apb_rsp_s;

endpackage

/* File: core/ttfs_wrap_counter.sv */
`timescale 1ns/100ps
`default_nettype none

module ttfs_wrap_counter #(
	parameter int W = 8
) (
	input  wire logic         i_core_clk,   // Core clock
	input  wire logic         i_sys_rst,    // Async reset, high
	input  wire logic         i_step,       // Advance one
	input  wire logic         i_load,       // Load value
	input  wire logic [W-1:0] i_load_value, // Value to load
	input  wire logic [W-1:0] i_last,       // Last count before wrap
	output logic      [W-1:0] o_count       // Current count
);

	logic [W-1:0] count;
	logic [W-1:0] next_count;

	always_comb
	begin
		next_count = count;
		if (i_load)
			next_count = i_load_value;
		else if (i_step)
			next_count = (count >= i_last) ? '0 : W'(count + 1'b1);
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			count <= '0;
		else
			count <= next_count;
	end

	assign o_count = count;

endmodule // ttfs_wrap_counter

`default_nettype wire

/* File: core/ttfs_pattern_match.sv */
`timescale 1ns/100ps
`default_nettype none

`include "ttfs_consts.svh"

module ttfs_pattern_match (
	input  wire logic [23:0] i_hist,     // F-bit history, bit 0 newest
	input  wire logic        i_esf,      // 1 = ESF, 0 = D4
	output logic             o_match,    // Some phase fits
	output logic      [4:0]  o_phase     // Position of newest bit
);

	localparam logic [11:0] D4_PAT  = `TTFS_D4_PATTERN;
	localparam logic [5:0]  ESF_PAT = `TTFS_ESF_PATTERN;

	// Tries every phase, last fit (lowest phase) wins
	always_comb
	begin
		logic ok;
		int   pos;
		o_match = 1'b0;
		o_phase = '0;
		ok      = 1'b0;
		pos     = 0;
		for (int p = 23; p >= 0; p--)
		begin
			ok = 1'b1;
			for (int k = 0; k < 24; k++)
			begin
				if (i_esf)
				begin
					pos = (p + 24 - k) % 24;
					if ((pos % 4) == 3 && i_hist[k] != ESF_PAT[pos / 4])
						ok = 1'b0;
				end
				else
				begin
					pos = (p + 24 - k) % 12;
					if (p > 11 || i_hist[k] != D4_PAT[pos])
						ok = 1'b0;
				end
			end
			if (ok)
			begin
				o_match = 1'b1;
				o_phase = 5'(p);
			end
		end
	end

endmodule // ttfs_pattern_match

`default_nettype wire

/* File: core/ttfs_tx_sync.sv */
// Function
// - Find the D4 or ESF frame boundary in the serial transmit data.
// - Also find the multiframe boundary in that data.
// - Format control bit 2 chooses D4 or ESF alignment search.
// - Latched status 3 bit 0 is set when frame sync is lost.
// - The live loss-of-frame flag is high while the search runs.
// - Latched loss bit, when its mask bit allows, pulls the low-active interrupt.
// - With the pin set as output the recovered frame pulse is driven on the sync pin.
// - With I/O config bit 0 set the sync pin carries the multiframe pulse instead.
// - The synchronizer idles while elastic store or interleaved bus mode is on.
// - Alignment uses framing patterns only, no CRC checking.
// - No CAS multiframe search is made.
// - Each framer has its own register space at a 200h index stride.
// - The sync control register holds the resynchronization controls.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

`include "ttfs_consts.svh"

module ttfs_tx_sync #(
	parameter int FRAMER_NUM = 1
) (
	input  wire logic                    i_core_clk,            // Core clock
	input  wire logic                    i_sys_rst,             // Async reset, high
	input  wire ttfs_pkg::ttfs_apb_req_s i_apb,                 // APB request
	output ttfs_pkg::ttfs_apb_rsp_s      o_apb,                 // APB response
	input  wire logic                    i_tx_serial_in,        // Serial transmit data
	input  wire logic                    i_tx_bit_strobe,       // One pulse per data bit
	input  wire logic                    i_tx_sync_pin_in,      // Sync pin level
	output logic                         o_tx_sync_pin_out,     // Sync pin drive value
	output logic                         o_tx_sync_pin_oe,      // Sync pin drive enable
	output logic                         o_loss_of_frame_live,  // Searching flag
	output logic                         o_interrupt_out_n      // Interrupt, low active
);

	localparam logic [11:0] FRAMER_OFS = 12'(FRAMER_NUM - 1) * `TTFS_FRAMER_STRIDE;
	localparam logic [11:0] A_FMT  = `TTFS_IDX_FMT_CTRL  + FRAMER_OFS;
	localparam logic [11:0] A_IO   = `TTFS_IDX_IO_CFG    + FRAMER_OFS;
	localparam logic [11:0] A_SYNC = `TTFS_IDX_SYNC_CTRL + FRAMER_OFS;
	localparam logic [11:0] A_LAT  = `TTFS_IDX_LAT_STAT3 + FRAMER_OFS;
	localparam logic [11:0] A_MASK = `TTFS_IDX_INT_MASK3 + FRAMER_OFS;
	localparam logic [11:0] A_ES   = `TTFS_IDX_ES_MODE   + FRAMER_OFS;
	localparam logic [11:0] A_STAT = `TTFS_IDX_SYNC_STAT + FRAMER_OFS;
	localparam logic [11:0] D4_PAT  = `TTFS_D4_PATTERN;
	localparam logic [5:0]  ESF_PAT = `TTFS_ESF_PATTERN;

	////////////////////////////////////////////////////////////////////////
	// APB slave and registers

	logic [7:0]              fmt_ctrl, next_fmt_ctrl;
	logic [7:0]              io_cfg, next_io_cfg;
	logic [7:0]              sync_ctrl, next_sync_ctrl;
	logic [7:0]              lat_stat, next_lat_stat;
	logic [7:0]              int_mask, next_int_mask;
	logic [7:0]              es_mode, next_es_mode;
	ttfs_pkg::ttfs_apb_rsp_s rsp, next_rsp;
	logic                    resync_req;
	logic                    loss_of_frame_detected_clr;
	logic                    loss_of_frame_detected_set;
	logic [7:0]              stat_rd;
	logic                    apb_access;
	logic                    apb_wr;
	logic [11:0]             idx;
	ttfs_pkg::ttfs_state_e   state, next_state;

	assign idx        = i_apb.paddr[13:2];
	assign apb_access = i_apb.psel && i_apb.penable && !rsp.pready;
	assign apb_wr     = i_apb.psel && i_apb.penable && rsp.pready && i_apb.pwrite;
	assign stat_rd    = {5'h00, (state == ttfs_pkg::S_LOCK), i_tx_sync_pin_in, (state == ttfs_pkg::S_HUNT)};

	always_comb
	begin
		next_fmt_ctrl  = fmt_ctrl;
		next_io_cfg    = io_cfg;
		next_sync_ctrl = sync_ctrl;
		next_int_mask  = int_mask;
		next_es_mode   = es_mode;
		next_rsp       = '0;
		resync_req     = 1'b0;
		loss_of_frame_detected_clr       = 1'b0;
		if (apb_access)
		begin
			next_rsp.pready = 1'b1;
			unique case (idx)
				A_FMT:   next_rsp.prdata = {24'h000000, fmt_ctrl};
				A_IO:    next_rsp.prdata = {24'h000000, io_cfg};
				A_SYNC:  next_rsp.prdata = {24'h000000, sync_ctrl};
				A_LAT:   next_rsp.prdata = {24'h000000, lat_stat};
				A_MASK:  next_rsp.prdata = {24'h000000, int_mask};
				A_ES:    next_rsp.prdata = {24'h000000, es_mode};
				A_STAT:  next_rsp.prdata = {24'h000000, stat_rd};
				default: next_rsp.pslverr = 1'b1;
			endcase
		end
		if (apb_wr && !rsp.pslverr)
		begin
			unique case (idx)
				A_FMT:  next_fmt_ctrl = i_apb.pwdata[7:0];
				A_IO:   next_io_cfg   = i_apb.pwdata[7:0];
				A_SYNC:
				begin
					next_sync_ctrl                   = i_apb.pwdata[7:0];
					next_sync_ctrl[`TTFS_RESYNC_BIT] = 1'b0;
					resync_req                       = i_apb.pwdata[`TTFS_RESYNC_BIT];
				end
				A_LAT:  loss_of_frame_detected_clr      = i_apb.pwdata[`TTFS_LOSS_OF_FRAME_DETECTED_BIT];
				A_MASK: next_int_mask = i_apb.pwdata[7:0];
				A_ES:   next_es_mode  = i_apb.pwdata[7:0];
				default:
				begin
				end
			endcase
		end
		// Set wins over a clear in the same cycle
		next_lat_stat                = '0;
		next_lat_stat[`TTFS_LOSS_OF_FRAME_DETECTED_BIT] = loss_of_frame_detected_set || (lat_stat[`TTFS_LOSS_OF_FRAME_DETECTED_BIT] && !loss_of_frame_detected_clr);
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			fmt_ctrl  <= `TTFS_REG_RST;
			io_cfg    <= `TTFS_REG_RST;
			sync_ctrl <= `TTFS_REG_RST;
			lat_stat  <= `TTFS_REG_RST;
			int_mask  <= `TTFS_REG_RST;
			es_mode   <= `TTFS_REG_RST;
			rsp       <= '0;
		end
		else
		begin
			fmt_ctrl  <= next_fmt_ctrl;
			io_cfg    <= next_io_cfg;
			sync_ctrl <= next_sync_ctrl;
			lat_stat  <= next_lat_stat;
			int_mask  <= next_int_mask;
			es_mode   <= next_es_mode;
			rsp       <= next_rsp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame alignment

	logic        esf;
	logic        sync_off;
	logic [4:0]  frame_last;
	logic [7:0]  bit_pos;
	logic [4:0]  frame_pos;
	logic        fbit;
	logic        pat_match;
	logic [4:0]  pat_phase;
	logic [4:0]  load_pos;
	logic        checked;
	logic        expected;
	logic [2:0]  err_thr;
	logic        lock_load;
	logic [23:0] hist, next_hist;
	logic [4:0]  hcnt, next_hcnt;
	logic        slip_pend, next_slip_pend;
	logic [2:0]  err_cnt, next_err_cnt;

	assign esf        = fmt_ctrl[`TTFS_FMT_SEL_BIT];
	assign sync_off   = es_mode[`TTFS_ES_EN_BIT] || es_mode[`TTFS_IBO_BIT];
	assign frame_last = esf ? `TTFS_ESF_LAST : `TTFS_D4_LAST;
	assign fbit       = i_tx_bit_strobe && (bit_pos == 8'h00) && !slip_pend;
	assign err_thr    = sync_ctrl[`TTFS_THR_SEL_BIT] ? `TTFS_ERR_THR_HI : `TTFS_ERR_THR_LO;
	assign load_pos   = (pat_phase >= frame_last) ? 5'h00 : 5'(pat_phase + 5'h01);
	// Only framing bits are compared; CRC and CAS are not looked at
	assign checked    = esf ? (frame_pos[1:0] == 2'h3) : 1'b1;
	assign expected   = esf ? ESF_PAT[frame_pos[4:2]] : D4_PAT[frame_pos[3:0]];

	ttfs_wrap_counter #(.W(8)) u_bit_counter (
		.i_core_clk   (i_core_clk),
		.i_sys_rst    (i_sys_rst),
		.i_step       (i_tx_bit_strobe && !slip_pend),
		.i_load       (1'b0),
		.i_load_value (8'h00),
		.i_last       (`TTFS_BIT_LAST),
		.o_count      (bit_pos)
	);

	ttfs_wrap_counter #(.W(5)) u_frame_counter (
		.i_core_clk   (i_core_clk),
		.i_sys_rst    (i_sys_rst),
		.i_step       (fbit && (state == ttfs_pkg::S_LOCK)),
		.i_load       (lock_load),
		.i_load_value (load_pos),
		.i_last       (frame_last),
		.o_count      (frame_pos)
	);

	ttfs_pattern_match u_pattern_match (
		.i_hist  (hist),
		.i_esf   (esf),
		.o_match (pat_match),
		.o_phase (pat_phase)
	);

	always_comb
	begin
		next_state     = state;
		next_hist      = hist;
		next_hcnt      = hcnt;
		next_slip_pend = slip_pend && !i_tx_bit_strobe;
		next_err_cnt   = err_cnt;
		lock_load      = 1'b0;
		unique case (state)
			ttfs_pkg::S_IDLE:
			begin
				next_hcnt = '0;
				if (!sync_off)
					next_state = ttfs_pkg::S_HUNT;
			end
			ttfs_pkg::S_HUNT:
			begin
				if (hcnt == `TTFS_HIST_LEN)
				begin
					next_hcnt = '0;
					if (pat_match)
					begin
						next_state   = ttfs_pkg::S_LOCK;
						lock_load    = 1'b1;
						next_err_cnt = '0;
					end
					else
						next_slip_pend = 1'b1;
				end
				else if (fbit)
				begin
					next_hist = {hist[22:0], i_tx_serial_in};
					next_hcnt = 5'(hcnt + 5'h01);
				end
			end
			ttfs_pkg::S_LOCK:
			begin
				if (fbit && checked)
				begin
					if (i_tx_serial_in == expected)
						next_err_cnt = '0;
					else
						next_err_cnt = 3'(err_cnt + 3'h1);
					if (i_tx_serial_in != expected && 3'(err_cnt + 3'h1) >= err_thr)
						next_state = ttfs_pkg::S_HUNT;
				end
			end
		endcase
		if (resync_req && state != ttfs_pkg::S_IDLE)
		begin
			next_state = ttfs_pkg::S_HUNT;
			next_hcnt  = '0;
		end
		if (sync_off)
			next_state = ttfs_pkg::S_IDLE;
	end

	assign loss_of_frame_detected_set = (state == ttfs_pkg::S_LOCK) && (next_state == ttfs_pkg::S_HUNT);

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			state     <= ttfs_pkg::S_IDLE;
			hist      <= '0;
			hcnt      <= '0;
			slip_pend <= 1'b0;
			err_cnt   <= '0;
		end
		else
		begin
			state     <= next_state;
			hist      <= next_hist;
			hcnt      <= next_hcnt;
			slip_pend <= next_slip_pend;
			err_cnt   <= next_err_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs

	logic next_pin_out;
	logic next_irq_n;

	always_comb
	begin
		next_pin_out = (state == ttfs_pkg::S_LOCK) && fbit;
		if (io_cfg[`TTFS_MF_SEL_BIT])
			next_pin_out = next_pin_out && (frame_pos == 5'h00);
		next_irq_n = !(lat_stat[`TTFS_LOSS_OF_FRAME_DETECTED_BIT] && int_mask[`TTFS_LOSS_OF_FRAME_DETECTED_MASK_BIT]);
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_tx_sync_pin_out    <= 1'b0;
			o_tx_sync_pin_oe     <= 1'b0;
			o_loss_of_frame_live <= 1'b0;
			o_interrupt_out_n    <= 1'b1;
		end
		else
		begin
			o_tx_sync_pin_out    <= next_pin_out;
			o_tx_sync_pin_oe     <= io_cfg[`TTFS_DIR_BIT];
			o_loss_of_frame_live <= (state == ttfs_pkg::S_HUNT);
			o_interrupt_out_n    <= next_irq_n;
		end
	end

	assign o_apb = rsp;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	property p_loss_of_frame_detected_set;
		(state == ttfs_pkg::S_HUNT) && ($past(state) == ttfs_pkg::S_LOCK) |-> lat_stat[0];
	endproperty
	a_loss_of_frame_detected_set: assert property (p_loss_of_frame_detected_set) else $error("loss bit not latched");

	property p_loss_of_frame_detected_hold;
		lat_stat[0] && !(apb_wr && idx == A_LAT && i_apb.pwdata[0]) |=> lat_stat[0];
	endproperty
	a_loss_of_frame_detected_hold: assert property (p_loss_of_frame_detected_hold) else $error("loss bit dropped");

	property p_live;
		(state == ttfs_pkg::S_HUNT) [*2] |-> o_loss_of_frame_live;
	endproperty
	a_live: assert property (p_live) else $error("live flag low in search");

	property p_irq;
		lat_stat[0] && int_mask[0] |=> !o_interrupt_out_n;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	property p_irq_masked;
		!int_mask[0] |=> o_interrupt_out_n;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt raised");

	property p_off;
		sync_off [*2] |=> (state == ttfs_pkg::S_IDLE) && !o_tx_sync_pin_out;
	endproperty
	a_off: assert property (p_off) else $error("runs with elastic store");

	property p_no_pulse;
		o_tx_sync_pin_out |-> $past(state) == ttfs_pkg::S_LOCK;
	endproperty
	a_no_pulse: assert property (p_no_pulse) else $error("pulse without lock");

	property p_mf_pulse;
		o_tx_sync_pin_out && $past(io_cfg[0]) |-> $past(frame_pos) == 5'h00;
	endproperty
	a_mf_pulse: assert property (p_mf_pulse) else $error("multiframe pulse misplaced");

	property p_slip;
		(state == ttfs_pkg::S_HUNT) && (hcnt == 5'd24) && !pat_match && !sync_off |=> slip_pend;
	endproperty
	a_slip: assert property (p_slip) else $error("no slip after failed hunt");

	property p_lock;
		(state == ttfs_pkg::S_HUNT) && (hcnt == 5'd24) && pat_match && !sync_off && !resync_req
			|=> (state == ttfs_pkg::S_LOCK);
	endproperty
	a_lock: assert property (p_lock) else $error("no lock on match");

	property p_resync;
		resync_req && (state == ttfs_pkg::S_LOCK) && !sync_off |=> (state == ttfs_pkg::S_HUNT) ##1 o_loss_of_frame_live;
	endproperty
	a_resync: assert property (p_resync) else $error("resync ignored");

	property p_apb;
		i_apb.psel && i_apb.penable && !rsp.pready |=> rsp.pready ##1 !rsp.pready;
	endproperty
	a_apb: assert property (p_apb) else $error("bad bus answer timing");

	c_lock: cover property ((state == ttfs_pkg::S_HUNT) ##1 (state == ttfs_pkg::S_LOCK));
	c_loss: cover property ((state == ttfs_pkg::S_LOCK) ##1 (state == ttfs_pkg::S_HUNT));
	c_mf:   cover property (o_tx_sync_pin_out && io_cfg[0]);
	c_irq:  cover property (!o_interrupt_out_n);

endmodule // ttfs_tx_sync

`default_nettype wire

/* File: testbench/ttfs_backplane_model.sv */
`timescale 1ns/100ps
`default_nettype none

module ttfs_backplane_model (
	input  wire logic i_core_clk, // Core clock
	input  wire logic i_sys_rst,  // Async reset, high
	input  wire logic i_run,      // Start streaming
	input  wire logic i_esf,      // 1 = ESF framing
	input  wire logic i_hit,      // Invert next two F-bits
	output logic      o_ser,      // Serial data
	output logic      o_stb       // Bit strobe
);
	// Frame bit patterns, first frame in bit 0
	localparam logic [11:0] D4_SEQ  = 12'h3b1;
	localparam logic [5:0]  ESF_SEQ = 6'h34;

	logic [7:0] bitc;
	logic [4:0] frm;
	logic [4:0] d4f;
	logic [1:0] bad;
	logic       tgl;
	logic       esf_f;
	logic       fbit;

	assign d4f = (frm > 5'd11) ? frm - 5'd12 : frm;
	// Non-pattern ESF F-bits follow frame count bit 0, no valid CRC
	assign esf_f = (frm[1:0] == 2'd3) ? ESF_SEQ[frm[4:2]] : frm[0];
	assign fbit = (i_esf ? esf_f : D4_SEQ[d4f[3:0]]) ^ (bad != 2'h0);

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			bitc  <= 8'h00;
			frm   <= 5'h00;
			bad   <= 2'h0;
			tgl   <= 1'b0;
			o_ser <= 1'b0;
			o_stb <= 1'b0;
		end
		else
		begin
			tgl   <= ~tgl;
			o_stb <= i_run & tgl;
			// Data only valid in its strobe cycle
			o_ser <= ~o_ser;
			if (i_hit)
				bad <= 2'h2;
			if (i_run && tgl)
			begin
				o_ser <= (bitc == 8'h00) ? fbit : bitc[0] ^ frm[1];
				bitc  <= (bitc == 8'hc0) ? 8'h00 : bitc + 8'h01;
				if (bitc == 8'hc0)
					frm <= (frm == 5'd23) ? 5'd0 : frm + 5'd1;
				if (bitc == 8'h00 && bad != 2'h0 && !i_hit)
					bad <= bad - 2'h1;
			end
		end
	end
endmodule // ttfs_backplane_model

`default_nettype wire

/* File: testbench/ttfs_tx_sync_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module ttfs_tx_sync_tb;
	localparam logic [11:0] FMT = 12'h183;
	localparam logic [11:0] IOC = 12'h184;
	localparam logic [11:0] SYC = 12'h18e;
	localparam logic [11:0] LST = 12'h192;
	localparam logic [11:0] IMK = 12'h1a2;
	localparam logic [11:0] ESM = 12'h1b0;
	localparam logic [11:0] STS = 12'h1b1;
	localparam logic [11:0] STRIDE = 12'h200;

	logic                    i_core_clk;
	logic                    i_sys_rst;
	ttfs_pkg::ttfs_apb_req_s req;
	ttfs_pkg::ttfs_apb_rsp_s rsp;
	logic                    ser;
	logic                    stb;
	logic                    pin_out;
	logic                    pin_oe;
	logic                    sync_pin;
	logic                    live;
	logic                    int_n;
	logic                    run;
	logic                    esf;
	logic                    hit;
	logic [31:0]             rd;
	logic                    err;
	logic [11:0]             regs [5];
	int                      mismatches;
	int                      samples_checked;
	int                      cycles;

	// Undriven sync pin reads low
	assign sync_pin = pin_oe ? pin_out : 1'b0;

	ttfs_tx_sync #(
		.FRAMER_NUM(2)
	) ttfs_tx_sync_inst (
		.i_core_clk          (i_core_clk),
		.i_sys_rst           (i_sys_rst),
		.i_apb               (req),
		.o_apb               (rsp),
		.i_tx_serial_in      (ser),
		.i_tx_bit_strobe     (stb),
		.i_tx_sync_pin_in    (sync_pin),
		.o_tx_sync_pin_out   (pin_out),
		.o_tx_sync_pin_oe    (pin_oe),
		.o_loss_of_frame_live(live),
		.o_interrupt_out_n   (int_n)
	);

	ttfs_backplane_model ttfs_backplane_model_inst (
		.i_core_clk(i_core_clk),
		.i_sys_rst (i_sys_rst),
		.i_run     (run),
		.i_esf     (esf),
		.i_hit     (hit),
		.o_ser     (ser),
		.o_stb     (stb)
	);

	////////////////////////////////////////
	initial
		i_core_clk = 1'b0;
	always #5 i_core_clk = ~i_core_clk;

	task automatic report_and_stop;
		$display("checked=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge i_core_clk)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr_en, input logic [11:0] idx, input logic [7:0] wd);
		req.psel   <= 1'b1;
		req.pwrite <= wr_en;
		req.paddr  <= {idx, 2'b00};
		req.pwdata <= {24'h000000, wd};
		@(posedge i_core_clk);
		req.penable <= 1'b1;
		@(posedge i_core_clk);
		// Only the bench timeout ends this wait
		while (rsp.pready !== 1'b1)
			@(posedge i_core_clk);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
		@(posedge i_core_clk);
	endtask

	task automatic wr(input logic [11:0] o, input logic [7:0] d);
		apb(1'b1, o + STRIDE, d);
	endtask

	task automatic rc(input logic [11:0] o, input logic [31:0] exp);
		apb(1'b0, o + STRIDE, 8'h00);
		chk(rd, exp);
	endtask

	// Bounded wait for live flag (0) or sync pulse (1)
	task automatic wait_sig(input logic which, input logic v);
		int n;
		n = 0;
		while ((which ? pin_out : live) !== v && n < 20000)
		begin
			n++;
			@(posedge i_core_clk);
		end
		chk({31'h0, (which ? pin_out : live)}, {31'h0, v});
	endtask

	// One frame is 193 strobes, two cycles apart
	task automatic cnt(input int frames, input logic [31:0] exp);
		logic [31:0] n;
		n = 32'h0;
		repeat (frames * 386)
		begin
			@(posedge i_core_clk);
			n = n + {31'h0, pin_out};
		end
		chk(n, exp);
	endtask

	////////////////////////////////////////
	initial
	begin
		req = '0;
		run = 1'b0;
		esf = 1'b0;
		hit = 1'b0;
		i_sys_rst = 1'b1;
		mismatches = 0;
		samples_checked = 0;
		cycles = 0;
		regs = '{FMT, IOC, SYC, LST, IMK};
		repeat (2) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		run       <= 1'b1;
		@(posedge i_core_clk);
		foreach (regs[i])
			rc(regs[i], 32'h0);
		apb(1'b0, FMT, 8'h00);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test registers done");

		chk({31'h0, live}, 32'h1);
		wait_sig(1'b0, 1'b0);
		rc(LST, 32'h0);
		wr(IOC, 8'h04);
		@(posedge i_core_clk);
		chk({31'h0, pin_oe}, 32'h1);
		cnt(24, 32'd24);
		wr(IOC, 8'h05);
		rc(IOC, 32'h5);
		cnt(24, 32'd2);
		$display("test d4 lock done");

		// Threshold of four rides out two errored F-bits
		wr(SYC, 8'h01);
		rc(SYC, 32'h1);
		hit <= 1'b1;
		@(posedge i_core_clk);
		hit <= 1'b0;
		repeat (1200) @(posedge i_core_clk);
		chk({31'h0, live}, 32'h0);
		rc(LST, 32'h0);
		rc(STS, 32'h4);
		wr(SYC, 8'h00);
		$display("test threshold done");

		wr(IMK, 8'h01);
		wr(IOC, 8'h04);
		hit <= 1'b1;
		@(posedge i_core_clk);
		hit <= 1'b0;
		wait_sig(1'b0, 1'b1);
		chk({31'h0, int_n}, 32'h0);
		rc(LST, 32'h1);
		wr(IMK, 8'h00);
		@(posedge i_core_clk);
		chk({31'h0, int_n}, 32'h1);
		wr(IMK, 8'h01);
		wait_sig(1'b0, 1'b0);
		rc(LST, 32'h1);
		chk({31'h0, int_n}, 32'h0);
		wr(LST, 8'h01);
		rc(LST, 32'h0);
		chk({31'h0, int_n}, 32'h1);
		$display("test loss done");

		wait_sig(1'b1, 1'b1);
		wr(FMT, 8'h04);
		wr(SYC, 8'h02);
		esf <= 1'b1;
		rc(SYC, 32'h0);
		wait_sig(1'b0, 1'b1);
		wait_sig(1'b0, 1'b0);
		rc(LST, 32'h1);
		wr(LST, 8'h01);
		wr(IOC, 8'h05);
		cnt(24, 32'd1);
		$display("test esf done");

		wr(IOC, 8'h04);
		for (int m = 1; m < 3; m++)
		begin
			wr(ESM, m[7:0]);
			repeat (2) @(posedge i_core_clk);
			chk({31'h0, live}, 32'h0);
			cnt(2, 32'd0);
		end
		$display("test idle done");

		// D4 stream into an ESF search never fits, so the hunt slips
		esf <= 1'b0;
		wr(ESM, 8'h00);
		repeat (9800) @(posedge i_core_clk);
		chk({31'h0, live}, 32'h1);
		rc(STS, 32'h1);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_core_clk);
		chk({31'h0, live}, 32'h0);
		rc(FMT, 32'h0);
		rc(IOC, 32'h0);
		chk({31'h0, pin_oe}, 32'h0);
		chk({31'h0, live}, 32'h1);
		$display("test slip and reset done");
		report_and_stop();
	end
endmodule // ttfs_tx_sync_tb

`default_nettype wire
